// file: design/usb_redriver_ctrl_status_regs.v
// USB path equalization, LFPS and compliance register bank
`timescale 1ns/1ns
`include "redriver_usb_defs.vh"
module usb_redriver_ctrl_status_regs #(
  parameter [`DEBOUNCE_W-1:0] DEBOUNCE_CYCLES = `LFPS_DEBOUNCE_CYCLES,
  parameter [`PERIOD_W-1:0]   DETECT_SHORT    = `DETECT_SHORT_CYCLES,
  parameter [`PERIOD_W-1:0]   DETECT_LONG     = `DETECT_LONG_CYCLES
) (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       eq_software_override,
  input  wire [1:0] down_eq_strap_pins,
  input  wire [1:0] up_eq_strap_pins,
  input  wire       lfps_present,
  input  wire       low_power_state,
  input  wire       fsm_compliance_req,
  output reg  [3:0] first_down_rx_eq_out,
  output reg  [3:0] second_down_rx_eq_out,
  output reg  [3:0] upstream_rx_eq_out,
  output reg        compliance_active_flag,
  output reg        compliance_force_down,
  output reg        compliance_force_up,
  output reg        rx_detect_enable,
  output reg        rx_detect_tick,
  output reg        low_power_exit
);

  // Register fields
  reg  [3:0]             first_down_rx_eq;
  reg  [3:0]             second_down_rx_eq;
  reg  [3:0]             upstream_rx_eq;
  reg                    apply_a;
  reg                    low_power_exit_debounce;
  reg                    low_power_detect_off;
  reg  [1:0]             down_detect_period;
  reg  [1:0]             compliance_force_ctrl;

  // Internal state
  reg  [`DEBOUNCE_W-1:0] debounce_cnt;
  reg  [`PERIOD_W-1:0]   period_cnt;
  reg                    next_compliance;
  reg  [7:0]             next_rdata;

  wire [1:0]             down_strap_s;
  wire [1:0]             up_strap_s;
  wire                   lfps_s;
  wire [3:0]             down_strap_lvl;
  wire [3:0]             up_strap_lvl;
  wire                   wr_down;
  wire                   wr_up;
  wire                   wr_ctrl;
  wire                   lfps_zero;
  wire                   exit_window;
  wire [`PERIOD_W-1:0]   period_len;
  wire                   period_wrap;
  wire                   next_detect_en;

  // Strap levels and LFPS detect come from pins
  pin_sync #(
    .W (5)
  ) u_pin_sync (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .clk_en       (clk_en),
    .pin_in       ({lfps_present, up_eq_strap_pins, down_eq_strap_pins}),
    .pin_sync_out ({lfps_s, up_strap_s, down_strap_s})
  );

  // Strap code to one of four levels
  function [3:0] strap_level;
    input [1:0] code;
    begin
      case (code)
        2'h0:    strap_level = `STRAP_LVL0;
        2'h1:    strap_level = `STRAP_LVL1;
        2'h2:    strap_level = `STRAP_LVL2;
        default: strap_level = `STRAP_LVL3;
      endcase
    end
  endfunction

  assign down_strap_lvl = strap_level(down_strap_s);
  assign up_strap_lvl   = strap_level(up_strap_s);

  // Write decode
  assign wr_down = reg_wr && (reg_addr == `ADDR_DOWN_EQ);
  assign wr_up   = reg_wr && (reg_addr == `ADDR_UP_EQ);
  assign wr_ctrl = reg_wr && (reg_addr == `ADDR_LINK_CTRL);

  // Equalization selects: straps track while override is clear
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      first_down_rx_eq  <= `RST_NIBBLE;
      second_down_rx_eq <= `RST_NIBBLE;
      upstream_rx_eq    <= `RST_NIBBLE;
    end
    else if (clk_en)
    begin
      if (!eq_software_override)
      begin
        first_down_rx_eq  <= down_strap_lvl;
        second_down_rx_eq <= down_strap_lvl;
        upstream_rx_eq    <= up_strap_lvl;
      end
      else
      begin
        if (wr_down)
        begin
          second_down_rx_eq <= reg_wdata[`EQ_HI_MSB:`EQ_HI_LSB];
          first_down_rx_eq  <= reg_wdata[`EQ_LO_MSB:`EQ_LO_LSB];
        end
        if (wr_up)
          upstream_rx_eq <= reg_wdata[`EQ_LO_MSB:`EQ_LO_LSB];
      end
    end
  end

  // Link control byte, bit 7 is not writable
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      apply_a                 <= 1'b0;
      low_power_exit_debounce <= 1'b0;
      low_power_detect_off    <= 1'b0;
      down_detect_period      <= `RST_PAIR;
      compliance_force_ctrl   <= `RST_PAIR;
    end
    else if (clk_en && wr_ctrl)
    begin
      apply_a                 <= reg_wdata[`BIT_LFPS_APPLY];
      low_power_exit_debounce <= reg_wdata[`BIT_LP_DEBOUNCE];
      low_power_detect_off    <= reg_wdata[`BIT_LP_DETECT_OFF];
      down_detect_period      <= reg_wdata[`PERIOD_MSB:`PERIOD_LSB];
      compliance_force_ctrl   <= reg_wdata[`COMPL_MSB:`COMPL_LSB];
    end
  end

  // Compliance mode source
  always @*
  begin
    case (compliance_force_ctrl)
      `COMPL_FORCE_DOWN: next_compliance = 1'b1;
      `COMPL_FORCE_UP:   next_compliance = 1'b1;
      `COMPL_OFF:        next_compliance = 1'b0;
      default:           next_compliance = fsm_compliance_req;
    endcase
  end

  // Compliance status and direction outputs
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      compliance_active_flag <= 1'b0;
      compliance_force_down  <= 1'b0;
      compliance_force_up    <= 1'b0;
    end
    else if (clk_en)
    begin
      compliance_active_flag <= next_compliance;
      compliance_force_down  <=
        (compliance_force_ctrl == `COMPL_FORCE_DOWN);
      compliance_force_up    <=
        (compliance_force_ctrl == `COMPL_FORCE_UP);
    end
  end

  // Applied equalization, zeroed during LFPS unless enabled
  assign lfps_zero = lfps_s && !apply_a;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      first_down_rx_eq_out  <= `EQ_ZERO;
      second_down_rx_eq_out <= `EQ_ZERO;
      upstream_rx_eq_out    <= `EQ_ZERO;
    end
    else if (clk_en)
    begin
      first_down_rx_eq_out  <= lfps_zero ? `EQ_ZERO : first_down_rx_eq;
      second_down_rx_eq_out <= lfps_zero ? `EQ_ZERO : second_down_rx_eq;
      upstream_rx_eq_out    <= lfps_zero ? `EQ_ZERO : upstream_rx_eq;
    end
  end

  // LFPS must persist through the debounce before U2/U3 exit
  assign exit_window = low_power_state && lfps_s;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      debounce_cnt   <= {`DEBOUNCE_W{1'b0}};
      low_power_exit <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!exit_window)
      begin
        debounce_cnt   <= {`DEBOUNCE_W{1'b0}};
        low_power_exit <= 1'b0;
      end
      else if (!low_power_exit_debounce)
        low_power_exit <= 1'b1;
      else if (debounce_cnt == DEBOUNCE_CYCLES - 1'b1)
        low_power_exit <= 1'b1;
      else
        debounce_cnt <= debounce_cnt + 1'b1;
    end
  end

  // Receiver detect period and suppression in U2/U3
  assign period_len = (down_detect_period == `PERIOD_12MS) ?
                      DETECT_LONG : DETECT_SHORT;
  assign period_wrap    = (period_cnt >= period_len - 1'b1);
  assign next_detect_en = !(low_power_state && low_power_detect_off);

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      period_cnt       <= {`PERIOD_W{1'b0}};
      rx_detect_enable <= 1'b0;
      rx_detect_tick   <= 1'b0;
    end
    else if (clk_en)
    begin
      period_cnt       <= period_wrap ? {`PERIOD_W{1'b0}} :
                          period_cnt + 1'b1;
      rx_detect_enable <= next_detect_en;
      rx_detect_tick   <= period_wrap && next_detect_en;
    end
  end

  // Read data mux, unmapped offsets read zero
  always @*
  begin
    next_rdata = `RST_BYTE;
    case (reg_addr)
      `ADDR_DOWN_EQ:
        next_rdata = {second_down_rx_eq, first_down_rx_eq};
      `ADDR_UP_EQ:
        next_rdata = {`RST_NIBBLE, upstream_rx_eq};
      `ADDR_LINK_CTRL:
        next_rdata = {compliance_active_flag, apply_a,
                      low_power_exit_debounce, low_power_detect_off,
                      down_detect_period, compliance_force_ctrl};
      default:
        next_rdata = `RST_BYTE;
    endcase
  end

  // Read data register
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= `RST_BYTE;
    else if (clk_en && reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule

// file: pkg/redriver_usb_defs.vh
// Constants for the USB path control and status register bank
`ifndef REDRIVER_USB_DEFS_VH
`define REDRIVER_USB_DEFS_VH

// Register offsets
`define ADDR_DOWN_EQ        8'h20
`define ADDR_UP_EQ          8'h21
`define ADDR_LINK_CTRL      8'h22

// Reset values
`define RST_BYTE            8'h00
`define RST_NIBBLE          4'h0
`define RST_PAIR            2'h0

// Field positions
`define EQ_HI_MSB           7
`define EQ_HI_LSB           4
`define EQ_LO_MSB           3
`define EQ_LO_LSB           0
`define BIT_COMPL_FLAG      7
`define BIT_LFPS_APPLY      6
`define BIT_LP_DEBOUNCE     5
`define BIT_LP_DETECT_OFF   4
`define PERIOD_MSB          3
`define PERIOD_LSB          2
`define COMPL_MSB           1
`define COMPL_LSB           0

// Encodings
`define PERIOD_8MS          2'h0
`define PERIOD_12MS         2'h1
`define COMPL_AUTO          2'h0
`define COMPL_FORCE_DOWN    2'h1
`define COMPL_FORCE_UP      2'h2
`define COMPL_OFF           2'h3
`define EQ_ZERO             4'h0

// Strap pin code to equalization level
`define STRAP_LVL0          4'h0
`define STRAP_LVL1          4'h5
`define STRAP_LVL2          4'ha
`define STRAP_LVL3          4'hf

// Timing
`define CLK_FREQ_MHZ        250
`define LFPS_DEBOUNCE_US    200
`define DETECT_SHORT_US     8000
`define DETECT_LONG_US      12000
// Cycle counts of the times above at 250 MHz, sized to the counters
`define LFPS_DEBOUNCE_CYCLES 16'hc350
`define DETECT_SHORT_CYCLES  22'h1e8480
`define DETECT_LONG_CYCLES   22'h2dc6c0

// Counter widths
`define DEBOUNCE_W          16
`define PERIOD_W            22

`endif

// file: design/pin_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire         clk_en,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync_out
);

  reg [W-1:0] stage1;

  // First stage feeds only the second
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1       <= {W{1'b0}};
      pin_sync_out <= {W{1'b0}};
    end
    else if (clk_en)
    begin
      stage1       <= pin_in;
      pin_sync_out <= stage1;
    end
  end

endmodule

// file: tb/usb_regs_asserts.sv
// Port assertions for the USB path register bank
`timescale 1ns/1ns
module usb_regs_asserts (
  input wire       clk_sys,
  input wire       resetn,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       low_power_state,
  input wire       compliance_active_flag,
  input wire       compliance_force_down,
  input wire       compliance_force_up,
  input wire       rx_detect_enable,
  input wire       rx_detect_tick,
  input wire       low_power_exit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_force_down: assert property (
    reg_wr && reg_addr == 8'h22 |-> ##2
    compliance_force_down == ($past(reg_wdata[1:0], 2) == 2'h1))
    else $error("force down wrong");
  a_force_up: assert property (
    $rose(compliance_force_up) |->
    $past(reg_wr && reg_addr == 8'h22 && reg_wdata[1:0] == 2'h2, 2))
    else $error("force up without write");
  a_flag_forced: assert property (
    compliance_force_down || compliance_force_up |-> compliance_active_flag)
    else $error("flag low while forced");
  a_reserved_zero: assert property (
    reg_rd && reg_addr == 8'h21 |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved bits set");
  a_unmapped_zero: assert property (
    reg_rd && (reg_addr < 8'h20 || reg_addr > 8'h22) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_detect_off: assert property (
    $fell(rx_detect_enable) |-> $past(low_power_state))
    else $error("detect off outside low power");
  a_exit_lp: assert property (
    low_power_exit |-> $past(low_power_state))
    else $error("exit outside low power");
  a_tick_pulse: assert property (
    rx_detect_tick |=> !rx_detect_tick)
    else $error("tick longer than a cycle");
endmodule

// file: tb/cfg_master.sv
// Configuration master model on the register strobe port
`timescale 1ns/1ns
module cfg_master (
  input  wire       clk_sys,
  input  wire [7:0] reg_rdata,
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata
);
  // Idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write, then an idle cycle so status settles
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;   // Released lines drop the old value
    reg_wdata = ~d;
    @(negedge clk_sys);
  end
  endtask
  // Read strobe; data is registered one cycle later
  task rd(input [7:0] a, output [7:0] d);
  begin
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  end
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the USB path register bank
`timescale 1ns/1ns
module tb_top;
  localparam [7:0] DS = 8'h28;
  localparam [7:0] DL = 8'h3c;
  localparam       DB = 20;
  reg        clk_sys;
  reg        resetn;
  reg        eq_software_override;
  reg  [1:0] down_eq_strap_pins;
  reg  [1:0] up_eq_strap_pins;
  reg        lfps_present;
  reg        low_power_state;
  reg        fsm_compliance_req;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire       reg_wr;
  wire       reg_rd;
  wire [3:0] first_down_rx_eq_out;
  wire [3:0] second_down_rx_eq_out;
  wire [3:0] upstream_rx_eq_out;
  wire       compliance_active_flag;
  wire       compliance_force_down;
  wire       compliance_force_up;
  wire       rx_detect_enable;
  wire       rx_detect_tick;
  wire       low_power_exit;
  wire [7:0] eq_dn = {second_down_rx_eq_out, first_down_rx_eq_out};
  reg  [7:0] d;
  reg  [7:0] e;
  reg  [7:0] w;
  integer    errors, n_checks, seed, cyc, tick_at, gap, i;

  usb_redriver_ctrl_status_regs #(.DEBOUNCE_CYCLES(16'h14),
    .DETECT_SHORT(22'h28), .DETECT_LONG(22'h3c))
  u_usb_redriver_ctrl_status_regs (.clk_sys, .resetn, .clk_en(1'b1),
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .eq_software_override, .down_eq_strap_pins, .up_eq_strap_pins,
    .lfps_present, .low_power_state, .fsm_compliance_req,
    .first_down_rx_eq_out, .second_down_rx_eq_out, .upstream_rx_eq_out,
    .compliance_active_flag, .compliance_force_down, .compliance_force_up,
    .rx_detect_enable, .rx_detect_tick, .low_power_exit);
  cfg_master u_cfg_master (.clk_sys, .reg_rdata, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata);

  // Strap code to applied level
  function [3:0] lv(input [1:0] c);
    lv = c * 4'h5;
  endfunction
  // Compare one result
  task chk(input [8*10:1] nm, input [7:0] exp, input [7:0] got);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("wrong value %0s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  // Read a register and compare with the model
  task rc(input [7:0] a, input [7:0] exp);
  begin
    u_cfg_master.rd(a, d);
    chk("readback", exp, d);
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Tick spacing, sampled off the launching edge, and hang guard
  always @(negedge clk_sys)
  begin
    cyc = cyc + 1;
    if (rx_detect_tick === 1'b1)
    begin
      gap = cyc - tick_at;
      tick_at = cyc;
    end
    if (cyc == 5000)
    begin
      errors = errors + 1;
      finish_test;
    end
  end
  // Main sequence
  initial
  begin
    seed = 32'hb473;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    tick_at = 0;
    gap = 0;
    resetn = 1'b0;
    eq_software_override = 1'b0;
    down_eq_strap_pins = 2'h0;
    up_eq_strap_pins = 2'h0;
    lfps_present = 1'b0;
    low_power_state = 1'b0;
    fsm_compliance_req = 1'b0;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    for (i = 0; i < 3; i = i + 1)
      rc(8'h20 + i[7:0], 8'h00);
    // Straps win over writes while override is clear
    for (i = 0; i < 4; i = i + 1)
    begin
      down_eq_strap_pins = i[1:0];
      up_eq_strap_pins = ~i[1:0];
      u_cfg_master.wr(8'h20, $random(seed));
      repeat (4) @(negedge clk_sys);
      e = {lv(i[1:0]), lv(i[1:0])};
      rc(8'h20, e);
      rc(8'h21, {4'h0, lv(~i[1:0])});
      chk("eq down", e, eq_dn);
    end
    eq_software_override = 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      e = $random(seed);
      w = $random(seed);
      u_cfg_master.wr(8'h20, e);
      u_cfg_master.wr(8'h21, w);
      rc(8'h20, e);
      rc(8'h21, {4'h0, w[3:0]});
      chk("eq down", e, eq_dn);
      chk("eq up", {4'h0, w[3:0]}, {4'h0, upstream_rx_eq_out});
    end
    rc(8'h30, 8'h00);
    // Every compliance code, random upper bits
    for (i = 0; i < 4; i = i + 1)
    begin
      d = $random(seed);
      fsm_compliance_req = d[7];
      w = {1'b0, d[6:2], i[1:0]};
      u_cfg_master.wr(8'h22, w);
      rc(8'h22, {i == 1 || i == 2 || (i == 0 && fsm_compliance_req),
        w[6:0]});
      chk("force", {5'h0, i == 1 || i == 2 || (i == 0 && fsm_compliance_req),
        i == 2, i == 1}, {5'h0, compliance_active_flag,
        compliance_force_up, compliance_force_down});
    end
    // Low power: no debounce, detect off, zero eq on LFPS
    low_power_state = 1'b1;
    lfps_present = 1'b1;
    u_cfg_master.wr(8'h22, 8'h10);
    repeat (4) @(negedge clk_sys);
    chk("exit", 8'h01, {7'h0, low_power_exit});
    chk("detect", 8'h00, {7'h0, rx_detect_enable});
    chk("eq lfps", 8'h00, eq_dn);
    chk("eq up", 8'h00, {4'h0, upstream_rx_eq_out});
    lfps_present = 1'b0;
    u_cfg_master.wr(8'h22, 8'h60);
    lfps_present = 1'b1;
    repeat (DB - 6) @(negedge clk_sys);
    chk("exit", 8'h00, {7'h0, low_power_exit});
    chk("detect", 8'h01, {7'h0, rx_detect_enable});
    chk("eq lfps", e, eq_dn);
    repeat (12) @(negedge clk_sys);
    chk("exit", 8'h01, {7'h0, low_power_exit});
    // Detect period for both defined codes
    u_cfg_master.wr(8'h22, 8'h00);
    repeat (100) @(negedge clk_sys);
    chk("period", DS, gap[7:0]);
    u_cfg_master.wr(8'h22, 8'h04);
    repeat (150) @(negedge clk_sys);
    chk("period", DL, gap[7:0]);
    finish_test;
  end
endmodule

bind usb_redriver_ctrl_status_regs usb_regs_asserts u_usb_regs_asserts (
  .clk_sys, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .low_power_state, .compliance_active_flag, .compliance_force_down,
  .compliance_force_up, .rx_detect_enable, .rx_detect_tick,
  .low_power_exit);
